// ==== bench/dual_channel_temp_monitor_ctrl_tb_top.sv ====
// Self-checking bench of the monitor control block
`timescale 1ns/100ps
module dual_channel_temp_monitor_ctrl_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, hw_standby_pin = 1'b1, sv, busy, al, oe_b;
    logic cfg_wr = 1'b0, rate_wr = 1'b0, lim_wr = 1'b0, cmd = 1'b0;
    logic [1:0] p0 = 2'b01, p1 = 2'b01;
    logic [7:0] cfg = 8'h00, rate = 8'h00, lh = 8'h7f, ll = 8'hc9, rh = 8'h7f, rl = 8'hc9;
    logic [7:0] lb = 8'd25, rb = 8'hec, ls, rs, lt, rt, cfg_o, rate_o;
    logic [3:0] st;
    logic [6:0] addr, prev;
    int failures = 0, compares = 0, cycles = 0, t0;
    tmon_ctrl #(.MEAS_CYC(50), .RATE_UNIT_CYC(100)) dut (
        .clock_in(clk), .rst_b_in(rst_b), .hw_standby_pin_in(hw_standby_pin),
        .addr_select_pin_0_in(p0), .addr_select_pin_1_in(p1),
        .config_in(cfg), .config_wr_in(cfg_wr), .rate_in(rate), .rate_wr_in(rate_wr),
        .local_high_in(lh), .local_low_in(ll), .remote_high_in(rh), .remote_low_in(rl),
        .limits_wr_in(lim_wr), .single_conversion_cmd_in(cmd), .sample_valid_in(sv),
        .local_sample_in(ls), .remote_sample_in(rs), .local_temp_out(lt),
        .remote_temp_out(rt), .status_out(st), .config_out(cfg_o), .rate_out(rate_o),
        .slave_addr_out(addr), .busy_out(busy), .alarm_pin_out(al),
        .alarm_pin_oe_b_out(oe_b));
    tmon_conv_model conv (.clock_in(clk), .rst_b_in(rst_b), .busy_in(busy),
        .local_base_in(lb), .remote_base_in(rb), .sample_valid_out(sv),
        .local_sample_out(ls), .remote_sample_out(rs));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========
    // Access tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Strobe k: 0 config, 1 rate, 2 limits, 3 single conversion
    task automatic pulse(input int k);
        {cmd, lim_wr, rate_wr, cfg_wr} = 4'(1 << k);
        step(1);
        {cmd, lim_wr, rate_wr, cfg_wr} = 4'h0;
        step(1);
    endtask
    task automatic wbusy(input logic v);
        int n;
        n = 0;
        while (busy !== v && n < 1200) begin
            step(1);
            n++;
        end
        chk("busy", 8'(v), 8'(busy));
    endtask
    task automatic idle(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            step(1);
            seen = seen | busy;
        end
        chk("idle", 8'h00, 8'(seen));
    endtask
    function automatic logic [7:0] avg(input logic [7:0] b);
        int s;
        s = 10 * int'($signed(b)) + 45;
        return 8'(s / 10);
    endfunction
    function automatic logic [6:0] ad(input int a, input int b);
        logic [3:0] up;
        up = a == 0 ? 4'h3 : (a == 1 ? 4'h5 : 4'h9);
        return {up, 3'((a == 2 ? 4 : a) + b)};
    endfunction
    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run;
        end
    end
    // ==========
    // Tests
    initial begin
        step(20);
        rst_b = 1'b1;
        chk("config", 8'h00, cfg_o);
        chk("rate", 8'h02, rate_o);
        chk("addr", 8'h2a, 8'(addr));
        chk("oe_b", 8'h01, 8'(oe_b));
        wbusy(1);
        wbusy(0);
        step(1);
        chk("local", avg(lb), lt);
        chk("remote", avg(rb), rt);
        chk("status", 8'h00, 8'(st));
        rate = 8'h04;
        pulse(1);
        chk("rate", 8'h04, rate_o);
        wbusy(1);
        t0 = cycles;
        wbusy(0);
        wbusy(1);
        // Start to start is (rate + 1) units of 100 cycles
        chk("gap", 8'h01, 8'(cycles - t0 == 500));
        rate = 8'h00;
        pulse(1);
        prev = 7'h2a;
        for (int i = 0; i < 9; i++) begin
            p0 = 2'(i / 3);
            p1 = 2'(i % 3);
            step(4);
            chk("addr", 8'(prev), 8'(addr));
            wbusy(0);
            wbusy(1);
            step(2);
            prev = ad(i / 3, i % 3);
            chk("addr", 8'(prev), 8'(addr));
        end
        lh = 8'd10;
        rl = 8'hf6;
        pulse(2);
        wbusy(0);
        wbusy(1);
        wbusy(0);
        step(1);
        chk("status", 8'h09, 8'(st));
        chk("oe_b", 8'h00, 8'(oe_b));
        chk("pin", 8'h00, 8'(al));
        cfg = 8'h80;
        pulse(0);
        chk("oe_b", 8'h01, 8'(oe_b));
        cfg = 8'h00;
        pulse(0);
        chk("oe_b", 8'h00, 8'(oe_b));
        lh = 8'h7f;
        rl = 8'hc9;
        pulse(2);
        wbusy(0);
        wbusy(1);
        wbusy(0);
        step(1);
        chk("status", 8'h00, 8'(st));
        cfg = 8'h40;
        pulse(0);
        chk("config", 8'h40, cfg_o);
        wbusy(0);
        idle(300);
        ll = 8'h05;
        rh = 8'h32;
        pulse(2);
        lb = 8'hfd;
        rb = 8'd60;
        pulse(3);
        wbusy(1);
        wbusy(0);
        step(1);
        chk("local", avg(lb), lt);
        chk("remote", avg(rb), rt);
        chk("status", 8'h06, 8'(st));
        chk("oe_b", 8'h00, 8'(oe_b));
        hw_standby_pin = 1'b0;
        cfg = 8'h00;
        pulse(0);
        step(4);
        pulse(3);
        idle(300);
        hw_standby_pin = 1'b1;
        wbusy(1);
        lb = 8'd50;
        step(20);
        hw_standby_pin = 1'b0;
        step(3);
        chk("abort", 8'h00, 8'(busy));
        idle(150);
        chk("local", avg(8'hfd), lt);
        complete_run;
    end
endmodule

// ==== bench/tmon_conv_model.sv ====
// Converter model that feeds paired samples to the control block
`timescale 1ns/100ps
module tmon_conv_model (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic busy_in,
    input wire logic [7:0] local_base_in,
    input wire logic [7:0] remote_base_in,
    output logic sample_valid_out,
    output logic [7:0] local_sample_out,
    output logic [7:0] remote_sample_out
);
    logic [2:0] tick_ff;
    logic [3:0] idx_ff;
    // ==========
    // One pair every 320 ns while busy, ten pairs per conversion
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_ff <= 3'h0;
            idx_ff <= 4'h0;
            sample_valid_out <= 1'b0;
            local_sample_out <= 8'h00;
            remote_sample_out <= 8'h00;
        end else begin
            tick_ff <= busy_in ? tick_ff + 3'h1 : 3'h0;
            idx_ff <= busy_in ? idx_ff : 4'h0;
            sample_valid_out <= 1'b0;
            // Idle data toggles so a stale value is never mistaken for a sample
            local_sample_out <= ~local_sample_out;
            remote_sample_out <= ~remote_sample_out;
            if (busy_in && tick_ff == 3'h7 && idx_ff < 4'ha) begin
                idx_ff <= idx_ff + 4'h1;
                sample_valid_out <= 1'b1;
                local_sample_out <= local_base_in + {4'h0, idx_ff};
                remote_sample_out <= remote_base_in + {4'h0, idx_ff};
            end
        end
    end
endmodule

// ==== core/tmon_ctrl.sv ====
// Conversion sequencing, limit compare, alarm and address logic of the monitor
`timescale 1ns/100ps
`include "tmon_defs.svh"

// Summary of operation
// - Free-running conversions while standby pin high and config bit 6 low.
// - Single conversion command adds one conversion beside periodic updates.
// - Rate register sets interval between free-running conversions.
// - Each conversion holds a measurement window of about 60 ms.
// - Results stored as 8-bit two's complement values.
// - After storing, compare against high and low limits into status flags.
// - Out-of-limit result pulls the active-low alarm pin low.
// - Both channel registers update together only on successful conversion.
// - Each result is the average of ten measurement cycles.
// - Each address pin resolves to low, high or unconnected.
// - Address pins are sampled at the start of every conversion.
// - Two three-level pins select one of nine bus addresses.
// - Normal operation with standby pin high, standby when low.
// - Standby entered by software bit or hardware pin.
// - Alarm is open-drain, usable as interrupt or bus alert.
// - Stored temperatures are readable by the host over the bus.
// - High and low trip limits are host programmable.
// - Address map: low/low 0011000, open/open 0101010, high/high 1001110.
// - Hardware standby ignores single command; software standby honours it.
// - Hardware standby during conversion aborts it, registers unchanged.
// - Config bit 7 masks alarm, bit 6 selects standby; both reset zero.
module tmon_ctrl #(
    parameter int MEAS_CYC = `TMON_MEAS_CYC,
    parameter int RATE_UNIT_CYC = `TMON_RATE_UNIT_CYC
) (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic hw_standby_pin_in,
    input wire logic [1:0] addr_select_pin_0_in,
    input wire logic [1:0] addr_select_pin_1_in,
    input wire logic [7:0] config_in,
    input wire logic config_wr_in,
    input wire logic [7:0] rate_in,
    input wire logic rate_wr_in,
    input wire logic [7:0] local_high_in,
    input wire logic [7:0] local_low_in,
    input wire logic [7:0] remote_high_in,
    input wire logic [7:0] remote_low_in,
    input wire logic limits_wr_in,
    input wire logic single_conversion_cmd_in,
    input wire logic sample_valid_in,
    input wire logic [7:0] local_sample_in,
    input wire logic [7:0] remote_sample_in,
    output logic [7:0] local_temp_out,
    output logic [7:0] remote_temp_out,
    output logic [3:0] status_out,
    output logic [7:0] config_out,
    output logic [7:0] rate_out,
    output logic [6:0] slave_addr_out,
    output logic busy_out,
    output logic alarm_pin_out,
    output logic alarm_pin_oe_b_out
);
    // Larger units would overflow the 32-bit period at rate 255
    if (MEAS_CYC < 10 || RATE_UNIT_CYC < 1 || RATE_UNIT_CYC > 16777215) begin : g_param_check
        $error("tmon_ctrl: timing parameters out of range");
    end

    // ==========================================================
    // Pin synchronisers
    logic [4:0] sync1_ff, sync2_ff;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_ff <= 5'h1f;
            sync2_ff <= 5'h1f;
        end else begin
            sync1_ff <= {hw_standby_pin_in, addr_select_pin_1_in, addr_select_pin_0_in};
            sync2_ff <= sync1_ff;
        end
    end
    logic hw_run;
    assign hw_run = sync2_ff[4];

    // Pin code 11 is not a legal level; it is read as unconnected
    function automatic logic [3:0] tmon_base(input logic [1:0] lvl);
        unique case (lvl)
            2'b00: tmon_base = `TMON_ADDR_BASE_LOW;
            2'b10: tmon_base = `TMON_ADDR_BASE_HIGH;
            default: tmon_base = `TMON_ADDR_BASE_OPEN;
        endcase
    endfunction
    // Low bits: offset chosen by pin 0, plus 0, 1 or 2 chosen by pin 1
    function automatic logic [2:0] tmon_low(input logic [1:0] lvl0, input logic [1:0] lvl1);
        logic [2:0] off;
        unique case (lvl0)
            2'b00: off = `TMON_ADDR_OFF_LOW;
            2'b10: off = `TMON_ADDR_OFF_HIGH;
            default: off = `TMON_ADDR_OFF_OPEN;
        endcase
        unique case (lvl1)
            2'b00: tmon_low = off;
            2'b10: tmon_low = off + 3'h2;
            default: tmon_low = off + 3'h1;
        endcase
    endfunction

    // ==========================================================
    // Configuration and limits
    logic [7:0] cfg_ff, nxt_cfg, rate_ff, nxt_rate;
    logic [7:0] lh_ff, ll_ff, rh_ff, rl_ff, nxt_lh, nxt_ll, nxt_rh, nxt_rl;
    always_comb begin
        nxt_cfg = config_wr_in ? config_in : cfg_ff;
        nxt_rate = rate_wr_in ? rate_in : rate_ff;
        nxt_lh = limits_wr_in ? local_high_in : lh_ff;
        nxt_ll = limits_wr_in ? local_low_in : ll_ff;
        nxt_rh = limits_wr_in ? remote_high_in : rh_ff;
        nxt_rl = limits_wr_in ? remote_low_in : rl_ff;
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_ff <= `TMON_CFG_RST;
            rate_ff <= `TMON_RATE_RST;
            lh_ff <= `TMON_HIGH_RST;
            ll_ff <= `TMON_LOW_RST;
            rh_ff <= `TMON_HIGH_RST;
            rl_ff <= `TMON_LOW_RST;
        end else begin
            cfg_ff <= nxt_cfg;
            rate_ff <= nxt_rate;
            lh_ff <= nxt_lh;
            ll_ff <= nxt_ll;
            rh_ff <= nxt_rh;
            rl_ff <= nxt_rl;
        end
    end
    logic sw_hw_standby_pin, alarm_mask, free_run;
    assign sw_hw_standby_pin = cfg_ff[`TMON_CFG_HW_STANDBY_PIN_BIT];
    assign alarm_mask = cfg_ff[`TMON_CFG_MASK_BIT];
    assign free_run = hw_run && !sw_hw_standby_pin;

    // ==========================================================
    // Conversion sequencer
    tmon_pkg::tmon_state_type st_ff, nxt_st;
    logic [31:0] tmr_ff, nxt_tmr, per_ff, nxt_per;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [11:0] lsum_ff, rsum_ff, nxt_lsum, nxt_rsum;
    logic pend_ff, nxt_pend;
    logic [3:0] addr_ff, nxt_addr;
    logic [6:0] sa_ff, nxt_sa;
    logic [7:0] lt_ff, rt_ff, nxt_lt, nxt_rt;
    logic [3:0] stat_ff, nxt_stat;
    logic [31:0] interval;
    logic start;
    assign interval = ({24'h0, rate_ff} + 32'd1) * RATE_UNIT_CYC;
    // Sign-extended sum of ten samples divided by ten
    function automatic logic [7:0] tmon_avg(input logic [11:0] s);
        logic signed [11:0] q;
        q = $signed(s) / 12'sd10;
        tmon_avg = q[7:0];
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_tmr = tmr_ff;
        nxt_per = per_ff;
        nxt_cnt = cnt_ff;
        nxt_lsum = lsum_ff;
        nxt_rsum = rsum_ff;
        nxt_addr = addr_ff;
        nxt_lt = lt_ff;
        nxt_rt = rt_ff;
        nxt_stat = stat_ff;
        start = 1'b0;
        // Command in hardware standby is dropped, not deferred
        nxt_pend = hw_run && (pend_ff || single_conversion_cmd_in);
        if (free_run) begin
            nxt_per = (per_ff >= interval - 32'd1) ? 32'h0 : per_ff + 32'd1;
        end else begin
            nxt_per = 32'h0;
        end
        unique case (st_ff)
            tmon_pkg::TMON_IDLE: begin
                if ((free_run && per_ff == 32'h0) || nxt_pend) begin
                    start = 1'b1;
                    nxt_pend = 1'b0;
                    nxt_st = tmon_pkg::TMON_MEAS;
                    nxt_tmr = 32'h0;
                    nxt_cnt = 4'h0;
                    nxt_lsum = 12'h0;
                    nxt_rsum = 12'h0;
                    nxt_addr = {sync2_ff[3:2], sync2_ff[1:0]};
                end
            end
            tmon_pkg::TMON_MEAS: begin
                if (!hw_run) begin
                    nxt_st = tmon_pkg::TMON_IDLE;
                end else begin
                    if (tmr_ff < MEAS_CYC) begin
                        nxt_tmr = tmr_ff + 32'd1;
                    end
                    if (sample_valid_in && cnt_ff < `TMON_AVG_COUNT) begin
                        nxt_cnt = cnt_ff + 4'h1;
                        nxt_lsum = lsum_ff + {{4{local_sample_in[7]}}, local_sample_in};
                        nxt_rsum = rsum_ff + {{4{remote_sample_in[7]}}, remote_sample_in};
                    end
                    if (tmr_ff >= MEAS_CYC && cnt_ff == `TMON_AVG_COUNT) begin
                        nxt_st = tmon_pkg::TMON_DONE;
                        nxt_lt = tmon_avg(lsum_ff);
                        nxt_rt = tmon_avg(rsum_ff);
                    end
                end
            end
            tmon_pkg::TMON_DONE: begin
                nxt_st = tmon_pkg::TMON_IDLE;
                nxt_stat = {$signed(lt_ff) > $signed(lh_ff), $signed(lt_ff) < $signed(ll_ff),
                            $signed(rt_ff) > $signed(rh_ff),
                            $signed(rt_ff) < $signed(rl_ff)};
            end
            default: nxt_st = tmon_pkg::TMON_IDLE;
        endcase
        nxt_sa = {tmon_base(nxt_addr[1:0]), tmon_low(nxt_addr[1:0], nxt_addr[3:2])};
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= tmon_pkg::TMON_IDLE;
            tmr_ff <= 32'h0;
            per_ff <= 32'h0;
            cnt_ff <= 4'h0;
            lsum_ff <= 12'h0;
            rsum_ff <= 12'h0;
            pend_ff <= 1'b0;
            addr_ff <= `TMON_ADDR_RST;
            sa_ff <= `TMON_SADDR_RST;
            lt_ff <= 8'h00;
            rt_ff <= 8'h00;
            stat_ff <= 4'h0;
        end else begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            per_ff <= nxt_per;
            cnt_ff <= nxt_cnt;
            lsum_ff <= nxt_lsum;
            rsum_ff <= nxt_rsum;
            pend_ff <= nxt_pend;
            addr_ff <= nxt_addr;
            sa_ff <= nxt_sa;
            lt_ff <= nxt_lt;
            rt_ff <= nxt_rt;
            stat_ff <= nxt_stat;
        end
    end

    // ==========================================================
    // Outputs
    assign local_temp_out = lt_ff;
    assign remote_temp_out = rt_ff;
    assign status_out = stat_ff;
    assign config_out = cfg_ff;
    assign rate_out = rate_ff;
    assign busy_out = (st_ff != tmon_pkg::TMON_IDLE);
    // Decoded once per conversion start, so the address comes from a flip-flop
    assign slave_addr_out = sa_ff;
    // Alarm follows the latched status; drives low only, never high
    assign alarm_pin_out = 1'b0;
    assign alarm_pin_oe_b_out = !((|stat_ff) && !alarm_mask);

    // ==========================================================
    // Assertions
    a_abort_keeps_regs: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (st_ff == tmon_pkg::TMON_MEAS && !hw_run) |=> $stable(lt_ff) && $stable(rt_ff))
        else $error("abort changed results");
    a_alarm_drive: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ((|stat_ff) && !alarm_mask) |-> !alarm_pin_oe_b_out)
        else $error("alarm not driven");
    a_mask_quiet: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        alarm_mask |-> alarm_pin_oe_b_out)
        else $error("masked alarm driven");
    a_hw_hw_standby_pin_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (!hw_run && st_ff == tmon_pkg::TMON_IDLE) |=> st_ff == tmon_pkg::TMON_IDLE)
        else $error("conversion in hw standby");
    a_cmd_dropped: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !hw_run |=> !pend_ff)
        else $error("command kept in hw standby");
    a_sw_hw_standby_pin_idle: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (sw_hw_standby_pin && st_ff == tmon_pkg::TMON_IDLE && !single_conversion_cmd_in && !pend_ff)
        |=> st_ff == tmon_pkg::TMON_IDLE)
        else $error("conversion in sw standby");
    a_free_start: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (free_run && st_ff == tmon_pkg::TMON_IDLE && per_ff == 32'h0)
        |=> st_ff == tmon_pkg::TMON_MEAS)
        else $error("free-run start missed");
    a_both_update: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ($changed(lt_ff) || $changed(rt_ff)) |-> $past(st_ff) == tmon_pkg::TMON_MEAS)
        else $error("result outside conversion");
    a_compare_follows: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        st_ff == tmon_pkg::TMON_DONE |=> stat_ff == {$signed(lt_ff) > $signed($past(lh_ff)),
            $signed(lt_ff) < $signed($past(ll_ff)), $signed(rt_ff) > $signed($past(rh_ff)),
            $signed(rt_ff) < $signed($past(rl_ff))})
        else $error("compare wrong");
    a_limits_load: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        limits_wr_in |=> lh_ff == $past(local_high_in) && ll_ff == $past(local_low_in)
            && rh_ff == $past(remote_high_in) && rl_ff == $past(remote_low_in))
        else $error("limit write lost");
    a_addr_stable: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !start |=> $stable(addr_ff) && $stable(sa_ff))
        else $error("address moved mid conversion");
    a_meas_window: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        nxt_st == tmon_pkg::TMON_DONE && st_ff == tmon_pkg::TMON_MEAS |-> tmr_ff >= MEAS_CYC)
        else $error("measurement window too short");
    a_ten_samples: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        nxt_st == tmon_pkg::TMON_DONE && st_ff == tmon_pkg::TMON_MEAS |-> cnt_ff == 4'd10)
        else $error("average count wrong");
endmodule

// ==== core/tmon_defs.svh ====
// Constants of the two-channel temperature monitor control block
`ifndef TMON_DEFS_SVH
`define TMON_DEFS_SVH
`define TMON_CLK_HZ 25000000
`define TMON_MEAS_MS 60
`define TMON_MEAS_CYC ((`TMON_CLK_HZ / 1000) * `TMON_MEAS_MS)
`define TMON_RATE_UNIT_CYC 32'd1000000
`define TMON_AVG_COUNT 4'd10
`define TMON_CFG_MASK_BIT 7
`define TMON_CFG_HW_STANDBY_PIN_BIT 6
`define TMON_CFG_RST 8'h00
`define TMON_RATE_RST 8'h02
`define TMON_HIGH_RST 8'h7f
`define TMON_LOW_RST 8'hc9
`define TMON_ADDR_BASE_LOW 4'h3
`define TMON_ADDR_BASE_OPEN 4'h5
`define TMON_ADDR_BASE_HIGH 4'h9
`define TMON_ADDR_OFF_LOW 3'h0
`define TMON_ADDR_OFF_OPEN 3'h1
`define TMON_ADDR_OFF_HIGH 3'h4
`define TMON_ADDR_RST 4'h5
`define TMON_SADDR_RST 7'h2a
`endif

// ==== core/tmon_pkg.sv ====
// Types of the two-channel temperature monitor control block
package tmon_pkg;
    typedef enum logic [1:0] {
        TMON_LVL_LOW = 2'b00,
        TMON_LVL_OPEN = 2'b01,
        TMON_LVL_HIGH = 2'b10
    } tmon_level_type;
    typedef enum logic [1:0] {
        TMON_IDLE = 2'b00,
        TMON_MEAS = 2'b01,
        TMON_DONE = 2'b10
    } tmon_state_type;
endpackage
